// ==== hdl/tcc_pkg.sv ====
package tcc_pkg;
   // -----------------------------------------------------------------
   // Register map (byte addresses on the bus)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_COUNT = 8'h04;
   localparam logic [7:0] ADR_CMP = 8'h08;
   localparam logic [7:0] ADR_FLAG = 8'h0C;
   localparam logic [7:0] ADR_MASK = 8'h10;
   localparam logic [7:0] ADR_ASYNC = 8'h14;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMP = 1;
   localparam int ASYNC_SEL = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] BOTTOM = 8'h00;
   localparam logic [7:0] MAX = 8'hFF;

   // -----------------------------------------------------------------
   // Modes, actions and clock selections
   // -----------------------------------------------------------------
   localparam logic [1:0] WM_NORMAL = 2'h0;
   localparam logic [1:0] WM_FAST = 2'h1;
   localparam logic [1:0] WM_CTC = 2'h2;
   localparam logic [1:0] WM_PHASE = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam int PRE_W = 10;

   // Control byte, bit 7 down to bit 0.
   typedef struct packed {
      logic force_compare_strobe;
      logic wave_mode_lo;
      logic [1:0] compare_action_field;
      logic wave_mode_hi;
      logic [2:0] clock_select_field;
   } tcc_ctrl_s;
endpackage : tcc_pkg

// ==== hdl/tcc_tick_gen.sv ====
`timescale 1ns/1ps
module tcc_tick_gen #(
   parameter int PW = tcc_pkg::PRE_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Selection
   input wire logic [2:0] clock_select_field_i,
   input wire logic async_clock_select_i,
   // Crystal pins
   input wire logic osc_pin_in_i,
   output logic osc_pin_out_o,
   // Timer clock pulse
   output logic timer_clock_o
);
   logic osc_q;
   logic [PW-1:0] pre;
   logic src;

   // -----------------------------------------------------------------
   // Prescaler mask for each clock selection
   // -----------------------------------------------------------------
   function automatic logic [PW-1:0] sel_mask(input logic [2:0] cs);
      case (cs)
         3'h2: sel_mask = PW'(7);
         3'h3: sel_mask = PW'(31);
         3'h4: sel_mask = PW'(63);
         3'h5: sel_mask = PW'(127);
         3'h6: sel_mask = PW'(255);
         3'h7: sel_mask = PW'(1023);
         default: sel_mask = '0;
      endcase
   endfunction : sel_mask

   // The crystal source ticks on each rising edge of the oscillator pin.
   assign src = async_clock_select_i ? (osc_pin_in_i & ~osc_q) : 1'b1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_q <= 1'b0;
         osc_pin_out_o <= 1'b1;
      end else begin
         osc_q <= osc_pin_in_i;
         osc_pin_out_o <= ~osc_pin_in_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clock_select_field_i == tcc_pkg::CS_STOP) begin
         pre <= '0;
      end else if (src) begin
         pre <= pre + PW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_clock_o <= 1'b0;
      end else begin
         timer_clock_o <= src &&
            clock_select_field_i != tcc_pkg::CS_STOP &&
            (pre & sel_mask(clock_select_field_i)) ==
            sel_mask(clock_select_field_i);
      end
   end
endmodule : tcc_tick_gen

// ==== hdl/tcc_timer8.sv ====
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Counter and compare registers are 8 bits.
// - Clock select zero stops the counter.
// - Async select takes clock from crystal.
// - Counter readable and writable without clock.
// - Processor counter write beats count/clear.
// - Each timer clock clears, increments, decrements.
// - Two wave mode bits set the sequence.
// - Bottom zero, max 255, top per mode.
// - Equality sets compare flag next timer clock.
// - Enabled flag requests irq, service clears.
// - Writing one clears compare flag.
// - Overflow flag set per mode, raises irq.
// - Compare buffered only in PWM modes.
// - Buffer loads at max in both PWM modes.
// - Access reaches buffer or active register.
// - Force strobe fakes match in non-PWM.
// - Force changes output only, no flag.
// - Counter write blocks next timer match.
// - Output state survives mode changes.
// - Action bits take effect immediately.
// - Mode zero counts up, wraps, no clear.
// - Normal overflow flag set reaching zero.
// - Mode two clears counter on match.
module tcc_timer8 (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Crystal pins
   input wire logic osc_pin_in_i,
   output logic osc_pin_out_o,
   // Interrupt requests and service acknowledges
   input wire logic ack_ovf_i,
   input wire logic ack_cmp_i,
   output logic irq_ovf_o,
   output logic irq_cmp_o,
   // Compare output state
   output logic compare_output_o
);
   tcc_pkg::tcc_ctrl_s ctrl;
   logic [7:0] counter_value;
   logic [7:0] compare_value;
   logic [7:0] cmp_buf;
   logic overflow_flag;
   logic compare_flag;
   logic [1:0] irq_en;
   logic async_clock_select;
   logic down;
   logic block;
   logic timer_clock;
   logic wr;
   logic [1:0] wm;
   logic pwm;
   logic eq;
   logic match;
   logic force_hit;
   logic [7:0] next_count;
   logic next_down;
   logic set_ovf;
   logic load_buf;
   logic [7:0] rd;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // A write takes effect on the edge where the master sees ack.
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wm = {ctrl.wave_mode_hi, ctrl.wave_mode_lo};
   assign pwm = wm == tcc_pkg::WM_FAST || wm == tcc_pkg::WM_PHASE;

   function automatic logic hit(input logic [7:0] a);
      hit = wb_adr_i == a;
   endfunction : hit

   always_comb begin
      case (wb_adr_i)
         tcc_pkg::ADR_CTRL: rd = {1'b0, ctrl[6:0]};
         tcc_pkg::ADR_COUNT: rd = counter_value;
         tcc_pkg::ADR_CMP: rd = pwm ? cmp_buf : compare_value;
         tcc_pkg::ADR_FLAG: rd = {6'h00, compare_flag, overflow_flag};
         tcc_pkg::ADR_MASK: rd = {6'h00, irq_en};
         tcc_pkg::ADR_ASYNC: rd = {7'h00, async_clock_select};
         default: rd = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= {24'h000000, rd};
      end
   end

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= tcc_pkg::tcc_ctrl_s'(tcc_pkg::RST_BYTE);
         irq_en <= 2'h0;
         async_clock_select <= 1'b0;
      end else if (wr) begin
         if (hit(tcc_pkg::ADR_CTRL)) begin
            ctrl <= tcc_pkg::tcc_ctrl_s'(wb_dat_i[7:0]);
            ctrl.force_compare_strobe <= 1'b0;
         end
         if (hit(tcc_pkg::ADR_MASK)) begin
            irq_en <= wb_dat_i[1:0];
         end
         if (hit(tcc_pkg::ADR_ASYNC)) begin
            async_clock_select <= wb_dat_i[tcc_pkg::ASYNC_SEL];
         end
      end
   end

   // Write-only strobe; a written PWM mode (bit 6 set) makes it void.
   assign force_hit = wr && hit(tcc_pkg::ADR_CTRL) &&
      wb_dat_i[7] && !wb_dat_i[6];

   // -----------------------------------------------------------------
   // Timer clock source
   // -----------------------------------------------------------------
   tcc_tick_gen #(
      .PW(tcc_pkg::PRE_W)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clock_select_field_i(ctrl.clock_select_field),
      .async_clock_select_i(async_clock_select),
      .osc_pin_in_i(osc_pin_in_i),
      .osc_pin_out_o(osc_pin_out_o),
      .timer_clock_o(timer_clock)
   );

   // -----------------------------------------------------------------
   // Counter sequence
   // -----------------------------------------------------------------
   assign eq = counter_value == compare_value;
   assign match = eq & ~block;

   always_comb begin
      next_count = counter_value + 8'h01;
      next_down = down;
      set_ovf = 1'b0;
      load_buf = 1'b0;
      case (wm)
         tcc_pkg::WM_NORMAL: begin
            set_ovf = counter_value == tcc_pkg::MAX;
         end
         tcc_pkg::WM_CTC: begin
            if (match) begin
               next_count = tcc_pkg::BOTTOM;
            end
            set_ovf = counter_value == tcc_pkg::MAX;
         end
         tcc_pkg::WM_FAST: begin
            set_ovf = counter_value == tcc_pkg::MAX;
            load_buf = counter_value == tcc_pkg::MAX;
         end
         tcc_pkg::WM_PHASE: begin
            if (counter_value == tcc_pkg::MAX) begin
               next_down = 1'b1;
               load_buf = 1'b1;
            end else if (counter_value == tcc_pkg::BOTTOM) begin
               next_down = 1'b0;
               set_ovf = down;
            end
            if (next_down) begin
               next_count = counter_value - 8'h01;
            end
         end
         default: begin
            next_count = counter_value;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value <= tcc_pkg::BOTTOM;
         down <= 1'b0;
      end else if (wr && hit(tcc_pkg::ADR_COUNT)) begin
         counter_value <= wb_dat_i[7:0];
      end else if (timer_clock) begin
         counter_value <= next_count;
         down <= next_down;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block <= 1'b0;
      end else if (wr && hit(tcc_pkg::ADR_COUNT)) begin
         block <= 1'b1;
      end else if (timer_clock) begin
         block <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Compare register and buffer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_value <= 8'h00;
         cmp_buf <= 8'h00;
      end else begin
         if (wr && hit(tcc_pkg::ADR_CMP)) begin
            cmp_buf <= wb_dat_i[7:0];
         end
         if (wr && hit(tcc_pkg::ADR_CMP) && !pwm) begin
            compare_value <= wb_dat_i[7:0];
         end else if (pwm && timer_clock && load_buf) begin
            compare_value <= cmp_buf;
         end
      end
   end

   // -----------------------------------------------------------------
   // Flags and interrupt requests
   // -----------------------------------------------------------------
   // Hardware set wins over a software or service clear.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_flag <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         if (timer_clock && match) begin
            compare_flag <= 1'b1;
         end else if ((wr && hit(tcc_pkg::ADR_FLAG) &&
               wb_dat_i[tcc_pkg::FLAG_CMP]) || ack_cmp_i) begin
            compare_flag <= 1'b0;
         end
         if (timer_clock && set_ovf && !(wr && hit(tcc_pkg::ADR_COUNT))) begin
            overflow_flag <= 1'b1;
         end else if ((wr && hit(tcc_pkg::ADR_FLAG) &&
               wb_dat_i[tcc_pkg::FLAG_OVF]) || ack_ovf_i) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_cmp_o <= 1'b0;
         irq_ovf_o <= 1'b0;
      end else begin
         irq_cmp_o <= compare_flag & irq_en[tcc_pkg::FLAG_CMP];
         irq_ovf_o <= overflow_flag & irq_en[tcc_pkg::FLAG_OVF];
      end
   end

   // -----------------------------------------------------------------
   // Compare output state
   // -----------------------------------------------------------------
   // Never touched by mode writes, so it survives mode changes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_output_o <= 1'b0;
      end else if (force_hit || (timer_clock && match && !pwm)) begin
         case (force_hit ? wb_dat_i[5:4] : ctrl.compare_action_field)
            tcc_pkg::ACT_TOGGLE: compare_output_o <= ~compare_output_o;
            tcc_pkg::ACT_CLEAR: compare_output_o <= 1'b0;
            tcc_pkg::ACT_SET: compare_output_o <= 1'b1;
            default: compare_output_o <= compare_output_o;
         endcase
      end else if (timer_clock && pwm &&
            ctrl.compare_action_field[1]) begin
         if (match) begin
            compare_output_o <= ctrl.compare_action_field[0] ^
               (wm == tcc_pkg::WM_PHASE && down);
         end else if (wm == tcc_pkg::WM_FAST &&
               counter_value == tcc_pkg::MAX) begin
            compare_output_o <= ~ctrl.compare_action_field[0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   property p_stop;
      @(posedge clk_i) disable iff (rst_i)
      $past(ctrl.clock_select_field) == tcc_pkg::CS_STOP &&
         !(wr && hit(tcc_pkg::ADR_COUNT)) |=> $stable(counter_value);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved");

   property p_cpu_wins;
      @(posedge clk_i) disable iff (rst_i)
      wr && hit(tcc_pkg::ADR_COUNT) |=> counter_value == $past(wb_dat_i[7:0]);
   endproperty
   a_cpu_wins: assert property (p_cpu_wins) else $error("write lost");

   property p_flag_set;
      @(posedge clk_i) disable iff (rst_i)
      timer_clock && eq && !block |=> compare_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("no flag");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
      compare_flag && irq_en[1] |=> irq_cmp_o;
   endproperty
   a_irq: assert property (p_irq) else $error("no irq");

   property p_w1c;
      @(posedge clk_i) disable iff (rst_i)
      wr && hit(tcc_pkg::ADR_FLAG) && wb_dat_i[1] && !(timer_clock && match)
         |=> !compare_flag;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag kept");

   property p_block;
      @(posedge clk_i) disable iff (rst_i)
      timer_clock && block && !compare_flag |=> !compare_flag;
   endproperty
   a_block: assert property (p_block) else $error("match not blocked");

   property p_normal_wrap;
      @(posedge clk_i) disable iff (rst_i)
      timer_clock && wm == tcc_pkg::WM_NORMAL &&
         counter_value == tcc_pkg::MAX && !wr
         |=> counter_value == tcc_pkg::BOTTOM && overflow_flag;
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("bad wrap");

   property p_ctc_clear;
      @(posedge clk_i) disable iff (rst_i)
      timer_clock && wm == tcc_pkg::WM_CTC && match && !wr
         |=> counter_value == tcc_pkg::BOTTOM;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("no clear");

   property p_force;
      @(posedge clk_i) disable iff (rst_i)
      force_hit && !(timer_clock && match) |=> !$rose(compare_flag);
   endproperty
   a_force: assert property (p_force) else $error("force set flag");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held");

   c_ovf: cover property (@(posedge clk_i) $rose(overflow_flag));
   c_cmp: cover property (@(posedge clk_i) $rose(compare_flag));
   c_force: cover property (@(posedge clk_i) force_hit);
   c_load: cover property (@(posedge clk_i) pwm && timer_clock && load_buf);
endmodule : tcc_timer8

// ==== verif/tcc_cpu_model.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Processor core stand-in: bus master and interrupt service
// -----------------------------------------------------------------
module tcc_cpu_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone master
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i,
   // Interrupt lines and service pulses
   input wire logic irq_ovf_i,
   input wire logic irq_cmp_i,
   output logic ack_ovf_o,
   output logic ack_cmp_o
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'hFF;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'hFFFFFFFF;
      ack_ovf_o = 1'b0;
      ack_cmp_o = 1'b0;
   end

   // One classic cycle; released lines show the inverse of the last value.
   task automatic bus_cycle(input logic we, input logic [7:0] adr,
      input logic [7:0] wdat, output logic [7:0] rdat);
      @(posedge clk_i);
      while (rst_i !== 1'b0) @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hF;
      wb_dat_o <= {24'h000000, wdat};
      do @(posedge clk_i); while (wb_ack_i !== 1'b1);
      rdat = wb_dat_i[7:0];
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~{24'h000000, wdat};
   endtask : bus_cycle

   // Only an interrupt that is actually requested gets serviced.
   task automatic service(input logic cmp);
      @(posedge clk_i);
      if (cmp && irq_cmp_i === 1'b1) ack_cmp_o <= 1'b1;
      if (!cmp && irq_ovf_i === 1'b1) ack_ovf_o <= 1'b1;
      @(posedge clk_i);
      ack_cmp_o <= 1'b0;
      ack_ovf_o <= 1'b0;
   endtask : service
endmodule : tcc_cpu_model

// ==== verif/tcc_timer8_tb_top.sv ====
`timescale 1ns/1ps
module tcc_timer8_tb_top;
   // -----------------------------------------------------------------
   // Clock, reset, crystal and wiring
   // -----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic osc_pin_in_i = 1'b0;
   logic [3:0] osc_div = 4'h0;
   logic wb_cyc, wb_stb, wb_we, wb_ack, ack_ovf, ack_cmp;
   logic irq_ovf, irq_cmp, cmp_out, osc_out;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   int n_errors = 0;
   int num_checks = 0;

   always #20 clk_i = ~clk_i;
   // Crystal stand-in: the pin flips every seven system clocks.
   always @(posedge clk_i) begin
      osc_div <= (osc_div == 4'h6) ? 4'h0 : osc_div + 4'h1;
      if (osc_div == 4'h6) osc_pin_in_i <= ~osc_pin_in_i;
   end

   tcc_timer8 tcc_timer8_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .osc_pin_in_i(osc_pin_in_i), .osc_pin_out_o(osc_out),
      .ack_ovf_i(ack_ovf), .ack_cmp_i(ack_cmp), .irq_ovf_o(irq_ovf),
      .irq_cmp_o(irq_cmp), .compare_output_o(cmp_out));
   tcc_cpu_model tcc_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
      .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
      .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack), .irq_ovf_i(irq_ovf),
      .irq_cmp_i(irq_cmp), .ack_ovf_o(ack_ovf), .ack_cmp_o(ack_cmp));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      logic [7:0] unused;
      tcc_cpu_model_inst.bus_cycle(1'b1, adr, dat, unused);
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [7:0] v);
      tcc_cpu_model_inst.bus_cycle(1'b0, adr, 8'h00, v);
   endtask : rd

   task automatic rd_chk(input string name, input logic [7:0] adr,
      input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] v;
      rd(adr, v);
      check(name, v & mask, exp);
   endtask : rd_chk

   // Counter read that must land inside [lo, hi].
   task automatic rd_range(input string name, input logic [7:0] lo,
      input logic [7:0] hi);
      logic [7:0] v;
      rd(tcc_pkg::ADR_COUNT, v);
      check(name, {7'h00, (v >= lo && v <= hi)}, 8'h01);
   endtask : rd_range

   function automatic logic [7:0] ctrl(input logic [1:0] wm,
      input logic [1:0] act, input logic [2:0] cs, input logic frc);
      tcc_pkg::tcc_ctrl_s c;
      c.force_compare_strobe = frc;
      c.wave_mode_lo = wm[0];
      c.wave_mode_hi = wm[1];
      c.compare_action_field = act;
      c.clock_select_field = cs;
      return c;
   endfunction : ctrl

   task automatic run(input logic [1:0] wm, input int n);
      wr(tcc_pkg::ADR_CTRL, ctrl(wm, 2'h0, tcc_pkg::CS_DIV1, 1'b0));
      idle(n);
      wr(tcc_pkg::ADR_CTRL, ctrl(wm, 2'h0, tcc_pkg::CS_STOP, 1'b0));
   endtask : run

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd_chk("ctrl", tcc_pkg::ADR_CTRL, 8'hFF, tcc_pkg::RST_BYTE);
      rd_chk("count", tcc_pkg::ADR_COUNT, 8'hFF, tcc_pkg::RST_BYTE);
      rd_chk("cmp", tcc_pkg::ADR_CMP, 8'hFF, tcc_pkg::RST_BYTE);
      rd_chk("flags", tcc_pkg::ADR_FLAG, 8'hFF, tcc_pkg::RST_BYTE);
      rd_chk("unmapped", 8'h3C, 8'hFF, 8'h00);
      check("out", {7'h00, cmp_out}, 8'h00);
   endtask : t_reset

   task automatic t_stopped();
      wr(tcc_pkg::ADR_COUNT, 8'h5A);
      idle(20);
      rd_chk("held", tcc_pkg::ADR_COUNT, 8'hFF, 8'h5A);
   endtask : t_stopped

   task automatic t_normal();
      wr(tcc_pkg::ADR_MASK, 8'h01);
      wr(tcc_pkg::ADR_COUNT, 8'hFD);
      run(tcc_pkg::WM_NORMAL, 4);
      rd_range("wrap", tcc_pkg::BOTTOM, 8'h10);
      rd_chk("ovf", tcc_pkg::ADR_FLAG, 8'h01, 8'h01);
      check("irq_ovf", {7'h00, irq_ovf}, 8'h01);
      tcc_cpu_model_inst.service(1'b0);
      idle(2);
      rd_chk("ovf_svc", tcc_pkg::ADR_FLAG, 8'h01, 8'h00);
      wr(tcc_pkg::ADR_MASK, 8'h00);
   endtask : t_normal

   task automatic t_compare();
      wr(tcc_pkg::ADR_FLAG, 8'h03);
      wr(tcc_pkg::ADR_CMP, 8'h40);
      wr(tcc_pkg::ADR_COUNT, 8'h40);
      run(tcc_pkg::WM_NORMAL, 1);
      rd_chk("blocked", tcc_pkg::ADR_FLAG, 8'h02, 8'h00);
      wr(tcc_pkg::ADR_MASK, 8'h02);
      wr(tcc_pkg::ADR_CTRL, ctrl(2'h0, 2'h0, tcc_pkg::CS_DIV1, 1'b0));
      wr(tcc_pkg::ADR_COUNT, 8'h3C);
      idle(4);
      wr(tcc_pkg::ADR_CTRL, ctrl(2'h0, 2'h0, tcc_pkg::CS_STOP, 1'b0));
      rd_range("cpu_wins", 8'h3D, 8'h4C);
      rd_chk("cmp_flag", tcc_pkg::ADR_FLAG, 8'h02, 8'h02);
      check("irq_cmp", {7'h00, irq_cmp}, 8'h01);
      wr(tcc_pkg::ADR_FLAG, 8'h00);
      rd_chk("zero_wr", tcc_pkg::ADR_FLAG, 8'h02, 8'h02);
      tcc_cpu_model_inst.service(1'b1);
      idle(2);
      rd_chk("cmp_svc", tcc_pkg::ADR_FLAG, 8'h02, 8'h00);
      check("irq_off", {7'h00, irq_cmp}, 8'h00);
      wr(tcc_pkg::ADR_MASK, 8'h00);
   endtask : t_compare

   task automatic t_ctc();
      wr(tcc_pkg::ADR_FLAG, 8'h03);
      wr(tcc_pkg::ADR_CMP, 8'h05);
      wr(tcc_pkg::ADR_COUNT, 8'h00);
      run(tcc_pkg::WM_CTC, 30);
      rd_range("ctc_top", 8'h00, 8'h05);
      rd_chk("ctc_flags", tcc_pkg::ADR_FLAG, 8'h03, 8'h02);
      wr(tcc_pkg::ADR_FLAG, 8'h02);
      rd_chk("one_wr", tcc_pkg::ADR_FLAG, 8'h02, 8'h00);
   endtask : t_ctc

   task automatic t_force();
      logic [1:0] acts [5];
      logic exp [5];
      acts = '{tcc_pkg::ACT_SET, tcc_pkg::ACT_CLEAR, tcc_pkg::ACT_TOGGLE,
         tcc_pkg::ACT_TOGGLE, tcc_pkg::ACT_SET};
      exp = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      wr(tcc_pkg::ADR_FLAG, 8'h03);
      wr(tcc_pkg::ADR_COUNT, 8'h22);
      for (int i = 0; i < 5; i++) begin
         wr(tcc_pkg::ADR_CTRL, ctrl(2'h0, acts[i], 3'h0, 1'b1));
         idle(2);
         check("forced", {7'h00, cmp_out}, {7'h00, exp[i]});
      end
      rd_chk("no_flag", tcc_pkg::ADR_FLAG, 8'h02, 8'h00);
      rd_chk("no_clear", tcc_pkg::ADR_COUNT, 8'hFF, 8'h22);
      wr(tcc_pkg::ADR_CTRL, ctrl(tcc_pkg::WM_FAST, 2'h2, 3'h0, 1'b1));
      idle(2);
      check("kept", {7'h00, cmp_out}, 8'h01);
   endtask : t_force

   task automatic t_buffer();
      wr(tcc_pkg::ADR_CTRL, 8'h00);
      wr(tcc_pkg::ADR_CMP, 8'hF0);
      wr(tcc_pkg::ADR_CTRL, ctrl(tcc_pkg::WM_FAST, 2'h0, 3'h0, 1'b0));
      wr(tcc_pkg::ADR_CMP, 8'h10);
      rd_chk("buf_rd", tcc_pkg::ADR_CMP, 8'hFF, 8'h10);
      wr(tcc_pkg::ADR_FLAG, 8'h03);
      wr(tcc_pkg::ADR_COUNT, 8'h0E);
      run(tcc_pkg::WM_FAST, 4);
      rd_chk("not_yet", tcc_pkg::ADR_FLAG, 8'h02, 8'h00);
      wr(tcc_pkg::ADR_COUNT, 8'hEC);
      run(tcc_pkg::WM_FAST, 8);
      rd_chk("old_act", tcc_pkg::ADR_FLAG, 8'h02, 8'h02);
      wr(tcc_pkg::ADR_FLAG, 8'h03);
      run(tcc_pkg::WM_FAST, 30);
      rd_chk("loaded", tcc_pkg::ADR_FLAG, 8'h03, 8'h03);
   endtask : t_buffer

   task automatic t_async();
      wr(tcc_pkg::ADR_CTRL, 8'h00);
      wr(tcc_pkg::ADR_ASYNC, 8'h01);
      wr(tcc_pkg::ADR_COUNT, 8'h00);
      run(tcc_pkg::WM_NORMAL, 100);
      rd_range("xtal", 8'h03, 8'h0C);
      wr(tcc_pkg::ADR_ASYNC, 8'h00);
      // Look while the crystal pin has been steady for a few clocks.
      do @(posedge clk_i); while (osc_div != 4'h3);
      check("osc_out", {7'h00, osc_out}, {7'h00, ~osc_pin_in_i});
   endtask : t_async

   task automatic t_phase();
      wr(tcc_pkg::ADR_CTRL, 8'h00);
      wr(tcc_pkg::ADR_COUNT, 8'hFD);
      wr(tcc_pkg::ADR_CTRL, ctrl(tcc_pkg::WM_PHASE, 2'h0, 3'h0, 1'b0));
      wr(tcc_pkg::ADR_CMP, 8'h33);
      run(tcc_pkg::WM_PHASE, 4);
      rd_range("phase_down", 8'hF0, 8'hFD);
      wr(tcc_pkg::ADR_CTRL, 8'h00);
      rd_chk("phase_load", tcc_pkg::ADR_CMP, 8'hFF, 8'h33);
   endtask : t_phase

   // -----------------------------------------------------------------
   // Sequence, watchdog and verdict
   // -----------------------------------------------------------------
   task automatic finish_test();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      idle(6);
      rst_i <= 1'b0;
      t_reset();
      t_stopped();
      t_normal();
      t_compare();
      t_ctc();
      t_force();
      t_buffer();
      t_phase();
      t_async();
      finish_test();
   end

   initial begin
      idle(20000);
      n_errors++;
      finish_test();
   end
endmodule : tcc_timer8_tb_top
